//--- aop_fifo.sv
// Result buffer between the converter and the output shift register.
`timescale 1ns/1ps
module aop_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Filling side.
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Draining side.
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  // Fill level.
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_q != FULL);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign o_count = cnt_q;
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule : aop_fifo

//--- aop_host_model.sv
// Behavioural host that clocks the slave serial port and feeds the chain input.
`timescale 1ns/1ps
module aop_host_model (
  // Serial data from the device.
  input wire logic i_sdo,
  // Clock and chain input towards the device.
  output logic o_sclk,
  output logic o_sdin
);
  logic inv = 1'b0;
  initial begin
    o_sclk = 1'b1;
    o_sdin = 1'b0;
  end
  // Parks the clock at its idle level before a frame, so no active edge is faked.
  task set_inv(input logic i);
    inv = i;
    o_sclk = ~i;
  endtask : set_inv
  // The clock stands still at its idle level between frames.
  task xfer(input int n, input logic [15:0] chain, output logic [31:0] got);
    logic [15:0] sh;
    sh = chain;
    o_sdin = sh[15];
    o_sclk = ~inv;
    got = '0;
    #207;
    for (int i = 0; i < n; i++) begin
      #80 o_sclk = inv;
      got = {got[30:0], i_sdo};
      #80 o_sclk = ~inv;
      sh = {sh[14:0], 1'b0};
      o_sdin = sh[15];
    end
    // Released line: show the inverse so a stale level is never mistaken for data.
    o_sdin = ~o_sdin;
  endtask : xfer
endmodule : aop_host_model

//--- aop_map.svh
// Register offsets, field positions, reset values and timing counts of the result port.
`ifndef AOP_MAP_SVH
`define AOP_MAP_SVH
`define AOP_CTRL_OFS 12'h000
`define AOP_STAT_OFS 12'h004
`define AOP_RSLT_OFS 12'h008
`define AOP_CTRL_W 6
`define AOP_CTRL_RST 6'h20
`define AOP_STAT_ERR_BIT 2
`define AOP_RES_W 16
`define AOP_CHAIN_DELAY 5'h10
`define AOP_LAST_BIT 5'h0f
`define AOP_SYNC_RST 4'h3
`define AOP_CLK_PERIOD_NS 20
`define AOP_SCLK_PERIOD_NS 60
`define AOP_SCLK_PHASES 3
`define AOP_MSCLK_DIV (`AOP_SCLK_PERIOD_NS / (`AOP_SCLK_PHASES * `AOP_CLK_PERIOD_NS))
`endif

//--- aop_pkg.sv
// Types shared by the result port files.
package aop_pkg;

  typedef struct packed {
    logic fmt_sb;
    logic rd_during;
    logic clk_inv;
    logic sync_inv;
    logic clk_ext;
    logic ser_sel;
  } aop_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MSHIFT = 2'b01,
    ST_SSHIFT = 2'b10,
    ST_PAR = 2'b11
  } aop_state_t;

endpackage : aop_pkg

//--- aop_result_port.sv
// Result output port of a 16-bit converter: parallel bus, serial port and register slave.
// Overview of operation
// - Format bit low inverts the result MSB, giving two's complement, on both ports.
// - Serial select low uses the parallel port; high turns some data pins serial.
// - Data bits 0 to 3 are driven as outputs in either mode whenever chip select and read strobe are low.
// - In parallel mode, the shared pins carry result bits 4 to 11 as data.
// - Serial with internal clock: the device makes the serial clock and drives it.
// - Serial with external clock: host supplies the clock, output follows that clock.
// - Frame sync is active high when its polarity select is low, else active low.
// - Clock invert flips the serial clock sense in master and slave operation.
// - External clock: chain input levels appear on serial data after 16 clock periods.
// - Internal clock: read mode high shifts during conversion, low only after it.
// - Each stored result leaves the shift register most significant bit first.
// - Internal clock: each serial bit stays stable across both edges of its period.
// - External clock, invert low: data changes on rising edge, host samples falling.
// - External clock, invert high: data changes on falling edge, host samples rising.
// - Internal clock: frame sync is active exactly while serial data bits are valid.
// - Slave read unfinished at next conversion end: data dropped, error flag pulses.
// - Output drivers are enabled only while chip select and read strobe are low.
// - Busy rises at conversion start and falls once the result is latched.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "aop_map.svh"
module aop_result_port #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  // AHB-Lite slave.
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Converter core.
  input wire logic I_CONV_START,
  input wire logic I_CONV_DONE,
  input wire logic [15:0] I_CONV_RESULT,
  output logic O_BUSY,
  // Host pins.
  input wire logic I_CS_N,
  input wire logic I_RD_N,
  input wire logic [15:0] I_DATA_IN,
  output logic [15:0] O_DATA_OUT,
  output logic [15:0] O_DATA_OE
);
  localparam logic [3:0] SYNC_RST = `AOP_SYNC_RST;
  localparam int unsigned MDIV = `AOP_MSCLK_DIV;
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  aop_pkg::aop_cfg_t cfg_q;
  aop_pkg::aop_state_t st_q;
  logic [3:0] pin_raw;
  logic [3:0] pin_q;
  logic cs_n;
  logic rd_n;
  logic sdin;
  logic ext_sclk;
  logic en;
  logic sclk_prev_q;
  logic sdin_smp_q;
  logic rise;
  logic fall;
  logic act_edge;
  logic smp_edge;
  logic ap_go;
  logic ap_wr_q;
  logic [11:0] ap_addr_q;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic busy_q;
  logic pend_v_q;
  logic [15:0] pend_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic [CW-1:0] fifo_cnt;
  logic push_fire;
  logic load;
  logic word_v_q;
  logic [15:0] word_q;
  logic [15:0] sh_q;
  logic [4:0] bit_cnt_q;
  logic [1:0] ph_q;
  logic [3:0] div_q;
  logic tick_q;
  logic rderr_q;
  logic err_seen_q;
  logic consume;
  logic abort;
  logic [15:0] pin_val;
  logic [15:0] pin_oe;
  logic [15:0] out_q;
  logic [15:0] oe_q;

  // Pin inputs: three flops, a change counts once the second and third agree.
  assign pin_raw = {I_DATA_IN[9], I_DATA_IN[7], I_RD_N, I_CS_N};
  for (genvar g = 0; g < 4; g++) begin : g_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic hold_q;
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
        s1_q <= SYNC_RST[g];
        s2_q <= SYNC_RST[g];
        s3_q <= SYNC_RST[g];
        hold_q <= SYNC_RST[g];
      end else begin
        s1_q <= pin_raw[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        hold_q <= pin_q[g];
      end
    end
    assign pin_q[g] = (s2_q == s3_q) ? s3_q : hold_q;
  end
  assign cs_n = pin_q[0];
  assign rd_n = pin_q[1];
  assign sdin = pin_q[2];
  assign ext_sclk = pin_q[3];
  assign en = !cs_n && !rd_n;

  // External clock edges; the active edge follows the clock invert bit.
  assign rise = ext_sclk && !sclk_prev_q;
  assign fall = !ext_sclk && sclk_prev_q;
  assign act_edge = cfg_q.clk_inv ? fall : rise;
  assign smp_edge = cfg_q.clk_inv ? rise : fall;

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      sclk_prev_q <= 1'b0;
      sdin_smp_q <= 1'b0;
    end else begin
      sclk_prev_q <= ext_sclk;
      if (smp_edge) begin
        sdin_smp_q <= sdin;
      end
    end
  end

  // Register slave: zero wait states, read data captured in the address phase.
  assign ap_go = I_HSEL && I_HTRANS[1] && I_HREADY;

  always_comb begin
    case (I_HADDR[11:0])
      `AOP_CTRL_OFS: rd_mux = {26'h0, cfg_q};
      `AOP_STAT_OFS: rd_mux = {20'h0, 4'(fifo_cnt), 2'h0, st_q, 1'b0, err_seen_q, word_v_q,
                               busy_q};
      `AOP_RSLT_OFS: rd_mux = {16'h0, word_q};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 12'h0;
      hrdata_q <= 32'h0;
      hready_q <= 1'b0;
    end else begin
      ap_wr_q <= ap_go && I_HWRITE;
      ap_addr_q <= I_HADDR[11:0];
      hrdata_q <= (ap_go && !I_HWRITE) ? rd_mux : 32'h0;
      hready_q <= 1'b1;
    end
  end

  // Selections live in a register because their pins serve as serial signals.
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cfg_q <= aop_pkg::aop_cfg_t'(`AOP_CTRL_RST);
    end else if (ap_wr_q && (ap_addr_q == `AOP_CTRL_OFS)) begin
      cfg_q <= aop_pkg::aop_cfg_t'(I_HWDATA[`AOP_CTRL_W-1:0]);
    end
  end

  // Sticky read error; a new error wins over a clear in the same cycle.
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      err_seen_q <= 1'b0;
    end else if (rderr_q) begin
      err_seen_q <= 1'b1;
    end else if (ap_wr_q && (ap_addr_q == `AOP_STAT_OFS) && I_HWDATA[`AOP_STAT_ERR_BIT]) begin
      err_seen_q <= 1'b0;
    end
  end

  // Busy and the pending result; a full buffer keeps busy high.
  assign push_fire = pend_v_q && fifo_in_ready;

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      busy_q <= 1'b0;
    end else if (I_CONV_START) begin
      busy_q <= 1'b1;
    end else if (push_fire) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      pend_v_q <= 1'b0;
      pend_q <= 16'h0;
    end else if (I_CONV_DONE) begin
      pend_v_q <= 1'b1;
      pend_q <= I_CONV_RESULT;
    end else if (fifo_in_ready) begin
      pend_v_q <= 1'b0;
    end
  end

  aop_fifo #(
    .WIDTH(`AOP_RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RESET),
    .i_in_valid(pend_v_q),
    .o_in_ready(fifo_in_ready),
    .i_in_data(pend_q),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(load),
    .o_out_data(fifo_out_data),
    .o_count(fifo_cnt)
  );

  // The output word only advances when no transfer can be disturbed.
  assign load = !word_v_q && fifo_out_valid && (st_q == aop_pkg::ST_IDLE)
                && (cfg_q.ser_sel || !en);

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      word_v_q <= 1'b0;
      word_q <= 16'h0;
    end else if (load) begin
      word_v_q <= 1'b1;
      word_q <= fifo_out_data ^ {cfg_q.fmt_sb == 1'b0, 15'h0};
    end else if (consume) begin
      word_v_q <= 1'b0;
    end
  end

  always_comb begin
    consume = 1'b0;
    abort = 1'b0;
    case (st_q)
      aop_pkg::ST_PAR: consume = !en;
      aop_pkg::ST_MSHIFT: consume = en && tick_q && (ph_q == 2'd2)
                                    && (bit_cnt_q == `AOP_LAST_BIT);
      aop_pkg::ST_SSHIFT: begin
        abort = en && I_CONV_DONE && (bit_cnt_q < `AOP_CHAIN_DELAY);
        consume = abort || (en && act_edge && (bit_cnt_q == `AOP_LAST_BIT));
      end
      default: consume = 1'b0;
    endcase
  end

  // Master clock divider: one tick per third of a serial clock period.
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      div_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      div_q <= (div_q == 4'(MDIV - 1)) ? 4'h0 : div_q + 4'h1;
      tick_q <= (div_q == 4'(MDIV - 1));
    end
  end

  // Transfer sequencer. Master bits take three phases so data never moves at an edge.
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      st_q <= aop_pkg::ST_IDLE;
      sh_q <= 16'h0;
      bit_cnt_q <= 5'h0;
      ph_q <= 2'd0;
      rderr_q <= 1'b0;
    end else begin
      rderr_q <= abort;
      case (st_q)
        aop_pkg::ST_IDLE: begin
          if (en && !cfg_q.ser_sel) begin
            st_q <= aop_pkg::ST_PAR;
          end else if (en && word_v_q) begin
            sh_q <= word_q;
            bit_cnt_q <= 5'h0;
            ph_q <= 2'd0;
            if (cfg_q.clk_ext) begin
              st_q <= aop_pkg::ST_SSHIFT;
            end else if (cfg_q.rd_during == busy_q) begin
              st_q <= aop_pkg::ST_MSHIFT;
            end
          end
        end
        aop_pkg::ST_PAR: begin
          if (!en) begin
            st_q <= aop_pkg::ST_IDLE;
          end
        end
        aop_pkg::ST_MSHIFT: begin
          if (!en) begin
            st_q <= aop_pkg::ST_IDLE;
          end else if (tick_q) begin
            if (ph_q == 2'd2) begin
              ph_q <= 2'd0;
              sh_q <= {sh_q[14:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 5'h1;
              if (bit_cnt_q == `AOP_LAST_BIT) begin
                st_q <= aop_pkg::ST_IDLE;
              end
            end else begin
              ph_q <= ph_q + 2'd1;
            end
          end
        end
        aop_pkg::ST_SSHIFT: begin
          if (!en || abort) begin
            st_q <= aop_pkg::ST_IDLE;
          end else if (act_edge) begin
            sh_q <= {sh_q[14:0], sdin_smp_q};
            if (bit_cnt_q < `AOP_CHAIN_DELAY) begin
              bit_cnt_q <= bit_cnt_q + 5'h1;
            end
          end
        end
        default: st_q <= aop_pkg::ST_IDLE;
      endcase
    end
  end

  // Pin values. In slave mode the next bit bypasses the shift register to save a cycle.
  always_comb begin
    pin_val = word_q;
    pin_oe = {16{en}};
    if (cfg_q.ser_sel) begin
      pin_oe[7:4] = 4'h0;
      if (st_q == aop_pkg::ST_IDLE) begin
        pin_val[8] = word_q[15];
      end else if ((st_q == aop_pkg::ST_SSHIFT) && act_edge) begin
        pin_val[8] = sh_q[14];
      end else begin
        pin_val[8] = sh_q[15];
      end
      pin_val[9] = ((st_q == aop_pkg::ST_MSHIFT) && (ph_q == 2'd1)) ^ cfg_q.clk_inv;
      pin_oe[9] = en && !cfg_q.clk_ext;
      pin_val[10] = (st_q == aop_pkg::ST_MSHIFT) ^ cfg_q.sync_inv;
      pin_oe[10] = en && !cfg_q.clk_ext;
      pin_val[11] = rderr_q;
      pin_oe[11] = en;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      out_q <= 16'h0;
      oe_q <= 16'h0;
    end else begin
      out_q <= pin_val;
      oe_q <= pin_oe;
    end
  end

  assign O_DATA_OUT = out_q;
  assign O_DATA_OE = oe_q;
  assign O_BUSY = busy_q;
  assign O_HRDATA = hrdata_q;
  assign O_HREADYOUT = hready_q;
  assign O_HRESP = 1'b0;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  sequence s_frame_start;
    (st_q == aop_pkg::ST_IDLE) && en && word_v_q && cfg_q.ser_sel;
  endsequence

  sequence s_err_pulse;
    rderr_q ##1 (out_q[11] && !rderr_q);
  endsequence

  chk_code_format: assert property (
    load |=> word_q[15] == ($past(fifo_out_data[15]) ^ !$past(cfg_q.fmt_sb)))
    else $error("Result format bit is wrong.");
  chk_serial_pins: assert property (
    (en && cfg_q.ser_sel) |=> oe_q[7:4] == 4'h0)
    else $error("Serial selection pins are driven.");
  chk_low_bits: assert property (
    en |=> oe_q[3:0] == 4'hf)
    else $error("Low data bits not driven.");
  chk_par_drive: assert property (
    (en && !cfg_q.ser_sel) |=> (oe_q == 16'hffff) && (out_q == $past(word_q)))
    else $error("Parallel bus not driven with the result.");
  chk_master_clk: assert property (
    ((st_q == aop_pkg::ST_MSHIFT) && en && cfg_q.ser_sel && !cfg_q.clk_ext) |=> oe_q[9])
    else $error("Master serial clock not driven.");
  chk_sync_level: assert property (
    ((st_q == aop_pkg::ST_MSHIFT) && cfg_q.ser_sel) |=> out_q[10] == !$past(cfg_q.sync_inv))
    else $error("Frame sync level is wrong.");
  chk_sclk_sense: assert property (
    ((st_q == aop_pkg::ST_IDLE) && cfg_q.ser_sel) |=> out_q[9] == $past(cfg_q.clk_inv))
    else $error("Idle serial clock sense is wrong.");
  chk_chain_fwd: assert property (
    ((st_q == aop_pkg::ST_SSHIFT) && en && !abort && act_edge) |=> sh_q[0] == $past(sdin_smp_q))
    else $error("Chain input not forwarded.");
  chk_read_mode: assert property (
    ($past(st_q == aop_pkg::ST_IDLE) && (st_q == aop_pkg::ST_MSHIFT))
    |-> $past(cfg_q.rd_during) == $past(busy_q))
    else $error("Master read started in the wrong read mode.");
  chk_msb_first: assert property (
    s_frame_start ##1 (st_q != aop_pkg::ST_IDLE) |-> sh_q == $past(word_q))
    else $error("Frame did not start with the stored result.");
  chk_bit_hold: assert property (
    ((st_q == aop_pkg::ST_MSHIFT) && $past(st_q == aop_pkg::ST_MSHIFT) && (ph_q != 2'd0))
    |-> $stable(sh_q))
    else $error("Master data bit moved inside its period.");
  chk_slave_update: assert property (
    ((st_q == aop_pkg::ST_SSHIFT) && $past(st_q == aop_pkg::ST_SSHIFT) && $changed(sh_q))
    |-> $past(act_edge))
    else $error("Slave data changed away from the active edge.");
  chk_sync_frame: assert property (
    ($past(st_q == aop_pkg::ST_MSHIFT) && (st_q == aop_pkg::ST_IDLE) && $past(en))
    |-> ($past(bit_cnt_q) == `AOP_LAST_BIT) && ($past(ph_q) == 2'd2))
    else $error("Frame sync ended before the last bit.");
  chk_read_error: assert property (
    (abort && cfg_q.ser_sel) |=> s_err_pulse)
    else $error("Incomplete read not flagged by one pulse.");
  chk_bus_enable: assert property (
    !en |=> oe_q == 16'h0)
    else $error("Drivers enabled without chip select and read.");
  chk_busy_fall: assert property (
    $fell(busy_q) |-> $past(push_fire) && !$past(I_CONV_START))
    else $error("Busy fell before the result was latched.");

endmodule : aop_result_port

//--- tb.sv
// Self-checking bench for the result port.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic cstart = 1'b0, cdone = 1'b0, busy, cs_n = 1'b1, rd_n = 1'b1, sclk, sdin;
  logic [15:0] cres = '0, dout, doe, w;
  int miscompares = 0, n_tests = 0, nb, ns;
  always #10 clk = ~clk;
  aop_result_port uut (.I_CORE_CLK(clk), .I_RESET(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hrdy), .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp),
    .I_CONV_START(cstart), .I_CONV_DONE(cdone), .I_CONV_RESULT(cres), .O_BUSY(busy),
    .I_CS_N(cs_n), .I_RD_N(rd_n), .I_DATA_IN({6'h00, sclk, 1'b0, sdin, 7'h00}),
    .O_DATA_OUT(dout), .O_DATA_OE(doe));
  aop_host_model host (.i_sdo(dout[8]), .o_sclk(sclk), .o_sdin(sdin));
  task give_verdict;
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask : ahb
  task reset_dut;
    rst <= 1'b1;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : reset_dut
  task start_c;
    @(posedge clk) cstart <= 1'b1;
    @(posedge clk) cstart <= 1'b0;
    #1 chk(busy, 1'b1);
  endtask : start_c
  task done_c(input logic [15:0] v);
    @(posedge clk) cdone <= 1'b1;
    cres <= v;
    @(posedge clk) cdone <= 1'b0;
  endtask : done_c
  task conv(input logic [15:0] v);
    start_c;
    done_c(v);
    repeat (3) @(posedge clk);
    #1 chk(busy, 1'b0);
  endtask : conv
  task en(input logic v);
    @(posedge clk) cs_n <= ~v;
    rd_n <= ~v;
  endtask : en
  // Collects bits at rising serial clock edges (falling ones when inv is set) while frame sync is active.
  task mcap(input logic inv, input logic pol);
    logic pc;
    pc = dout[9] ^ inv;
    w = '0;
    nb = 0;
    ns = 0;
    repeat (300) begin
      @(negedge clk);
      if (dout[10] === ~pol) begin
        ns++;
        if ((dout[9] ^ inv) && !pc) begin
          w = {w[14:0], dout[8]};
          nb++;
        end
      end else if (ns > 0) begin
        break;
      end
      pc = dout[9] ^ inv;
    end
  endtask : mcap
  task t_regs;
    reset_dut;
    ahb(1'b0, 12'h000, '0);
    chk(r, 32'h00000020);
    chk(hresp, 1'b0);
    ahb(1'b0, 12'h004, '0);
    chk(r, 32'h00000000);
    ahb(1'b1, 12'h00c, 32'hffffffff);
    ahb(1'b0, 12'h00c, '0);
    chk(r, 32'h00000000);
    ahb(1'b1, 12'h000, 32'h00000015);
    ahb(1'b0, 12'h000, '0);
    chk(r, 32'h00000015);
  endtask : t_regs
  task t_par;
    reset_dut;
    ahb(1'b1, 12'h000, 32'h00000020);
    conv(16'ha5c3);
    ahb(1'b0, 12'h008, '0);
    chk(r, 32'h0000a5c3);
    @(posedge clk) cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk(doe, 16'h0000);
    en(1'b1);
    repeat (8) @(posedge clk);
    #1 chk(doe, 16'hffff);
    chk(dout, 16'ha5c3);
    en(1'b0);
    repeat (8) @(posedge clk);
    #1 chk(doe, 16'h0000);
    ahb(1'b1, 12'h000, 32'h00000000);
    conv(16'h1234);
    en(1'b1);
    repeat (8) @(posedge clk);
    #1 chk(dout, 16'h9234);
    en(1'b0);
  endtask : t_par
  task t_master_after;
    reset_dut;
    ahb(1'b1, 12'h000, 32'h00000021);
    done_c(16'hc35a);
    start_c;
    en(1'b1);
    repeat (20) @(negedge clk);
    chk(dout[10], 1'b0);
    chk(doe, 16'hff0f);
    done_c(16'h0001);
    mcap(1'b0, 1'b0);
    chk(w, 16'hc35a);
    chk(nb, 16);
    chk(ns, 48);
    en(1'b0);
  endtask : t_master_after
  task t_master_during;
    reset_dut;
    ahb(1'b1, 12'h000, 32'h0000003d);
    done_c(16'h5a3c);
    start_c;
    en(1'b1);
    mcap(1'b1, 1'b1);
    chk(w, 16'h5a3c);
    chk(ns, 48);
    chk(nb, 16);
    en(1'b0);
  endtask : t_master_during
  task t_slave(input logic inv, input logic [15:0] v, input logic [15:0] ch);
    logic [31:0] got;
    host.set_inv(inv);
    reset_dut;
    ahb(1'b1, 12'h000, {28'h0000002, inv, 3'h3});
    conv(v);
    en(1'b1);
    repeat (8) @(posedge clk);
    #1 chk(doe, 16'hf90f);
    host.xfer(32, ch, got);
    chk(got, {v, ch});
    en(1'b0);
  endtask : t_slave
  task t_rderr;
    logic [31:0] got;
    int cnt;
    host.set_inv(1'b0);
    reset_dut;
    ahb(1'b1, 12'h000, 32'h00000023);
    conv(16'h0f0f);
    en(1'b1);
    repeat (8) @(posedge clk);
    host.xfer(4, 16'h0000, got);
    done_c(16'h1111);
    cnt = 0;
    repeat (10) begin
      @(negedge clk);
      if (dout[11] === 1'b1) cnt++;
    end
    chk(cnt, 1);
    en(1'b0);
    ahb(1'b0, 12'h004, '0);
    chk(r[2], 1'b1);
    ahb(1'b1, 12'h004, 32'h00000004);
    ahb(1'b0, 12'h004, '0);
    chk(r[2], 1'b0);
  endtask : t_rderr
  initial begin
    #1ms;
    miscompares++;
    give_verdict;
  end
  initial begin
    #7;
    t_regs;
    t_par;
    t_master_after;
    t_master_during;
    t_slave(1'b0, 16'hb671, 16'h3c96);
    t_slave(1'b1, 16'h8e15, 16'hd24b);
    t_rderr;
    give_verdict;
  end
endmodule : tb
